// ---- src/lld_pkg.sv ----
// Shared constants, field layout and carrier types for the loop lock and divider configuration block
package lld_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Serial configuration frame
   localparam int         LLD_WORD_W   = 32;
   localparam int         LLD_ADDR_W   = 5;
   localparam logic [4:0] LLD_ADDR_FLT = 5'h18;
   localparam logic [4:0] LLD_ADDR_DAC = 5'h19;
   localparam logic [4:0] LLD_ADDR_CP2 = 5'h1A;
   localparam logic [4:0] LLD_ADDR_CP1 = 5'h1B;

   // Reset values: every divider and count starts at its smallest legal value
   localparam logic [31:0] LLD_FLT_RST = 32'h0000_0000;
   localparam logic [31:0] LLD_DAC_RST = 32'h0040_0040;
   localparam logic [31:0] LLD_CP2_RST = 32'h8000_0040;
   localparam logic [31:0] LLD_CP1_RST = 32'h0000_0040;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int LLD_R3_LSB    = 16;
   localparam int LLD_NDLY_LSB  = 12;
   localparam int LLD_RDLY_LSB  = 8;
   localparam int LLD_WND1_LSB  = 6;
   localparam int LLD_DDIV_LSB  = 22;
   localparam int LLD_CNT_LSB   = 6;
   localparam int LLD_WND2_LSB  = 30;
   localparam int LLD_DBL_BIT   = 29;
   localparam int LLD_POL_BIT   = 28;
   localparam int LLD_GAIN_LSB  = 26;
   localparam int LLD_HIZ_BIT   = 5;
   localparam int LLD_PRE0_LSB  = 20;
   localparam int LLD_RDIV_LSB  = 6;

   ////////////////////////////////////////////////////////////////////////
   // Lock windows, delay step and pump currents
   localparam logic [15:0] LLD_WND1_0_PS = 16'd5500;
   localparam logic [15:0] LLD_WND1_1_PS = 16'd10000;
   localparam logic [15:0] LLD_WND1_2_PS = 16'd18600;
   localparam logic [15:0] LLD_WND1_3_PS = 16'd40000;
   localparam logic [15:0] LLD_WND2_PS   = 16'd3700;
   localparam logic [10:0] LLD_DLY_STEP_PS = 11'd205;
   localparam logic [11:0] LLD_CP_100_UA  = 12'd100;
   localparam logic [11:0] LLD_CP_200_UA  = 12'd200;
   localparam logic [11:0] LLD_CP_400_UA  = 12'd400;
   localparam logic [11:0] LLD_CP_1600_UA = 12'd1600;
   localparam logic [11:0] LLD_CP_3200_UA = 12'd3200;
   localparam logic [14:0] LLD_R3_OHM_0 = 15'd200;
   localparam logic [14:0] LLD_R3_OHM_1 = 15'd1000;
   localparam logic [14:0] LLD_R3_OHM_2 = 15'd2000;
   localparam logic [14:0] LLD_R3_OHM_3 = 15'd4000;
   localparam logic [14:0] LLD_R3_OHM_4 = 15'd16000;

   // Pin synchroniser lanes
   localparam int LLD_PIN_SCLK  = 0;
   localparam int LLD_PIN_SDATA = 1;
   localparam int LLD_PIN_LATCH = 2;
   localparam int LLD_PIN_REF   = 3;
   localparam int LLD_NPIN      = 4;

   ////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic        valid;
      logic [15:0] err_ps;
   } lld_phase_s;

   typedef struct packed {
      logic        pos_pol;
      logic [11:0] current_ua;
   } lld_pump_s;

endpackage

// ---- src/lld_lock_counter.sv ----
// Digital lock detect counter for one loop, advanced once per phase-detector cycle
`timescale 1ns/1ps
module lld_lock_counter
   import lld_pkg::*;
#(
   parameter int CNT_W = 14
)(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // Phase detector result and settings
   input  wire lld_phase_s       phase,
   input  wire logic [15:0]      window_ps,
   input  wire logic [CNT_W-1:0] target,
   // Lock state
   output logic [CNT_W-1:0]      count_reg,
   output logic                  locked_reg
);

   logic [CNT_W-1:0] eff_target;
   logic             in_window;

   // A zero count is reserved; it behaves as one
   assign eff_target = (target == '0) ? {{(CNT_W-1){1'b0}}, 1'b1} : target;
   assign in_window  = phase.err_ps < window_ps;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         count_reg  <= '0;
         locked_reg <= 1'b0;
      end else if (phase.valid) begin
         if (!in_window) begin
            count_reg  <= '0;
            locked_reg <= 1'b0;
         end else if (count_reg < eff_target) begin
            count_reg  <= count_reg + 1'b1;
            locked_reg <= (count_reg + 1'b1) == eff_target;
         end else begin
            locked_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   a_miss_clears_lock: assert property (@(posedge clk) disable iff (!nrst)
      phase.valid && !in_window |=> !locked_reg && count_reg == '0)
      else $error("out-of-window cycle did not clear lock");

   a_lock_needs_count: assert property (@(posedge clk) disable iff (!nrst)
      $rose(locked_reg) |-> count_reg >= eff_target && $past(phase.valid))
      else $error("lock rose before count reached");

endmodule // lld_lock_counter

// ---- src/lld_top.sv ----
// Configuration registers, lock detect, reference and tuning-DAC dividers of the dual-loop conditioner
//
// Function
// - Loop one counts up while phase error is below its 2-bit window.
// - Loop one locks after the programmed 14-bit count; zero is reserved.
// - Loop two counts up while phase error is below its window.
// - Loop two locks after its programmed 14-bit count; zero is reserved.
// - Tuning-DAC update clock is loop-one compare rate over a 10-bit divisor.
// - Each input has a prescaler dividing by 1, 2, 4 or 8.
// - The prescaler of the active input is the one applied.
// - Loop-one reference divides by its 14-bit code; zero is reserved.
// - Feedback delay is code times 205 ps, up to 1435 ps.
// - Reference delay is code times 205 ps, up to 1435 ps.
// - Doubler bit passes loop-two reference at once or twice the rate.
// - Loop-two pump current 100/400/1600/3200 uA; tri-state forces high impedance.
// - Loop-two pump pin is driven unless its tri-state bit is set.
// - Loop-one pump polarity bit: 0 negative, 1 positive.
// - Loop-one pump current 100/200/400/1600 uA; tri-state forces high impedance.
// - Filter resistor code 0..4 gives 200, 1k, 2k, 4k, 16k ohm.
// - Loop-one pump pin is driven unless its tri-state bit is set.
`timescale 1ns/1ps
module lld_top
   import lld_pkg::*;
#(
   parameter int LOCK_CNT_W = 14,
   parameter int RDIV_W     = 14,
   parameter int DDIV_W     = 10
)(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // Serial configuration pins
   input  wire logic        cfg_sclk,
   input  wire logic        cfg_sdata,
   input  wire logic        cfg_latch,
   // Reference path
   input  wire logic        reference_clock_input,
   input  wire logic [1:0]  active_input,
   // Phase detector results
   input  wire lld_phase_s  first_phase,
   input  wire lld_phase_s  second_phase,
   // Lock and divider outputs
   output logic             first_loop_locked,
   output logic             second_loop_locked,
   output logic             first_loop_ref_tick,
   output logic             tune_dac_update,
   // Analog settings
   output lld_pump_s        first_pump,
   output lld_pump_s        second_pump,
   output logic             first_loop_pump_pin_oe,
   output logic             second_loop_pump_pin_oe,
   output logic [10:0]      first_loop_feedback_delay_ps,
   output logic [10:0]      first_loop_reference_delay_ps,
   output logic             second_loop_reference_doubler_enable,
   output logic [14:0]      second_loop_filter_ohms,
   output logic             second_loop_filter_code_bad
);

   ////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic logic [10:0] delay_ps(input logic [2:0] code);
      delay_ps = 11'(code * LLD_DLY_STEP_PS);
   endfunction

   function automatic logic [11:0] pump_ua(input logic loop2, input logic [1:0] gain,
                                           input logic hiz);
      if (hiz) begin
         pump_ua = 12'h000;
      end else begin
         case (gain)
            2'h0:    pump_ua = LLD_CP_100_UA;
            2'h1:    pump_ua = loop2 ? LLD_CP_400_UA : LLD_CP_200_UA;
            2'h2:    pump_ua = loop2 ? LLD_CP_1600_UA : LLD_CP_400_UA;
            default: pump_ua = loop2 ? LLD_CP_3200_UA : LLD_CP_1600_UA;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; a level is accepted once stages two and three agree

   logic [LLD_NPIN-1:0] sync1_reg;
   logic [LLD_NPIN-1:0] sync2_reg;
   logic [LLD_NPIN-1:0] sync3_reg;
   logic [LLD_NPIN-1:0] pin_reg;
   logic [LLD_NPIN-1:0] pin_rise;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
      end else begin
         sync1_reg <= {reference_clock_input, cfg_latch, cfg_sdata, cfg_sclk};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pin_reg <= '0;
      end else begin
         pin_reg <= (sync2_reg & sync3_reg) | (pin_reg & (sync2_reg | sync3_reg));
      end
   end

   assign pin_rise = sync2_reg & sync3_reg & ~pin_reg;

   ////////////////////////////////////////////////////////////////////////
   // Serial frame: MSB first, address in the low five bits, taken on latch rise

   logic [LLD_WORD_W-1:0] shift_reg;
   logic [31:0]           flt_reg;
   logic [31:0]           dac_reg;
   logic [31:0]           cp2_reg;
   logic [31:0]           cp1_reg;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         shift_reg <= '0;
      end else if (pin_rise[LLD_PIN_SCLK]) begin
         shift_reg <= {shift_reg[LLD_WORD_W-2:0], pin_reg[LLD_PIN_SDATA]};
      end
   end

   // Frames for other addresses belong to other blocks and are ignored here
   always_ff @(posedge clk) begin
      if (!nrst) begin
         flt_reg <= LLD_FLT_RST;
         dac_reg <= LLD_DAC_RST;
         cp2_reg <= LLD_CP2_RST;
         cp1_reg <= LLD_CP1_RST;
      end else if (pin_rise[LLD_PIN_LATCH]) begin
         case (shift_reg[LLD_ADDR_W-1:0])
            LLD_ADDR_FLT: flt_reg <= shift_reg;
            LLD_ADDR_DAC: dac_reg <= shift_reg;
            LLD_ADDR_CP2: cp2_reg <= shift_reg;
            LLD_ADDR_CP1: cp1_reg <= shift_reg;
            default:      flt_reg <= flt_reg;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Lock detect

   logic [15:0]           first_window_ps;
   logic [LOCK_CNT_W-1:0] first_count;
   logic [LOCK_CNT_W-1:0] second_count;

   always_comb begin
      case (flt_reg[LLD_WND1_LSB +: 2])
         2'h0:    first_window_ps = LLD_WND1_0_PS;
         2'h1:    first_window_ps = LLD_WND1_1_PS;
         2'h2:    first_window_ps = LLD_WND1_2_PS;
         default: first_window_ps = LLD_WND1_3_PS;
      endcase
   end

   lld_lock_counter #(.CNT_W(LOCK_CNT_W)) u_first_lock (
      .clk        (clk),
      .nrst       (nrst),
      .phase      (first_phase),
      .window_ps  (first_window_ps),
      .target     (dac_reg[LLD_CNT_LSB +: LOCK_CNT_W]),
      .count_reg  (first_count),
      .locked_reg (first_loop_locked)
   );

   // Only code 2 is legal, so every code is treated as the 3.7 ns window
   lld_lock_counter #(.CNT_W(LOCK_CNT_W)) u_second_lock (
      .clk        (clk),
      .nrst       (nrst),
      .phase      (second_phase),
      .window_ps  (LLD_WND2_PS),
      .target     (cp2_reg[LLD_CNT_LSB +: LOCK_CNT_W]),
      .count_reg  (second_count),
      .locked_reg (second_loop_locked)
   );

   ////////////////////////////////////////////////////////////////////////
   // Tuning-DAC update divider

   logic [DDIV_W-1:0] dac_div_eff;
   logic [DDIV_W-1:0] dac_cnt_reg;

   assign dac_div_eff = (dac_reg[LLD_DDIV_LSB +: DDIV_W] == '0) ?
                        {{(DDIV_W-1){1'b0}}, 1'b1} : dac_reg[LLD_DDIV_LSB +: DDIV_W];

   always_ff @(posedge clk) begin
      if (!nrst) begin
         dac_cnt_reg     <= '0;
         tune_dac_update <= 1'b0;
      end else if (first_phase.valid) begin
         if (dac_cnt_reg >= dac_div_eff - 1'b1) begin
            dac_cnt_reg     <= '0;
            tune_dac_update <= 1'b1;
         end else begin
            dac_cnt_reg     <= dac_cnt_reg + 1'b1;
            tune_dac_update <= 1'b0;
         end
      end else begin
         tune_dac_update <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reference path: prescaler of the active input, then the reference divider

   logic [1:0]        pre_code;
   logic [2:0]        pre_max;
   logic [2:0]        pre_cnt_reg;
   logic [1:0]        act_reg;
   logic              pre_done;
   logic [RDIV_W-1:0] rdiv_eff;
   logic [RDIV_W-1:0] rdiv_cnt_reg;

   // Input 3 does not exist; it falls back to input 0
   assign pre_code = (active_input == 2'h3) ? cp1_reg[LLD_PRE0_LSB +: 2] :
                     cp1_reg[LLD_PRE0_LSB + 2 * active_input +: 2];
   assign pre_max  = 3'((4'h1 << pre_code) - 4'h1);
   assign pre_done = pin_rise[LLD_PIN_REF] && (pre_cnt_reg >= pre_max);
   assign rdiv_eff = (cp1_reg[LLD_RDIV_LSB +: RDIV_W] == '0) ?
                     {{(RDIV_W-1){1'b0}}, 1'b1} : cp1_reg[LLD_RDIV_LSB +: RDIV_W];

   // A switch restarts the prescaler so the divider never sees a mixed period
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pre_cnt_reg <= '0;
         act_reg     <= 2'h0;
      end else begin
         act_reg <= active_input;
         if (act_reg != active_input) begin
            pre_cnt_reg <= '0;
         end else if (pin_rise[LLD_PIN_REF]) begin
            pre_cnt_reg <= pre_done ? 3'h0 : pre_cnt_reg + 3'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdiv_cnt_reg        <= '0;
         first_loop_ref_tick <= 1'b0;
      end else if (pre_done && act_reg == active_input) begin
         if (rdiv_cnt_reg >= rdiv_eff - 1'b1) begin
            rdiv_cnt_reg        <= '0;
            first_loop_ref_tick <= 1'b1;
         end else begin
            rdiv_cnt_reg        <= rdiv_cnt_reg + 1'b1;
            first_loop_ref_tick <= 1'b0;
         end
      end else begin
         first_loop_ref_tick <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Analog setting outputs

   always_ff @(posedge clk) begin
      if (!nrst) begin
         first_pump                           <= '0;
         second_pump                          <= '0;
         first_loop_pump_pin_oe               <= 1'b0;
         second_loop_pump_pin_oe              <= 1'b0;
         first_loop_feedback_delay_ps         <= '0;
         first_loop_reference_delay_ps        <= '0;
         second_loop_reference_doubler_enable <= 1'b0;
      end else begin
         second_pump.pos_pol    <= cp2_reg[LLD_POL_BIT];
         second_pump.current_ua <= pump_ua(1'b1, cp2_reg[LLD_GAIN_LSB +: 2],
                                           cp2_reg[LLD_HIZ_BIT]);
         first_pump.pos_pol     <= cp1_reg[LLD_POL_BIT];
         first_pump.current_ua  <= pump_ua(1'b0, cp1_reg[LLD_GAIN_LSB +: 2],
                                           cp1_reg[LLD_HIZ_BIT]);
         second_loop_pump_pin_oe <= !cp2_reg[LLD_HIZ_BIT];
         first_loop_pump_pin_oe  <= !cp1_reg[LLD_HIZ_BIT];
         first_loop_feedback_delay_ps  <= delay_ps(flt_reg[LLD_NDLY_LSB +: 3]);
         first_loop_reference_delay_ps <= delay_ps(flt_reg[LLD_RDLY_LSB +: 3]);
         second_loop_reference_doubler_enable <= cp2_reg[LLD_DBL_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         second_loop_filter_ohms     <= LLD_R3_OHM_0;
         second_loop_filter_code_bad <= 1'b0;
      end else begin
         second_loop_filter_code_bad <= 1'b0;
         case (flt_reg[LLD_R3_LSB +: 3])
            3'h0:    second_loop_filter_ohms <= LLD_R3_OHM_0;
            3'h1:    second_loop_filter_ohms <= LLD_R3_OHM_1;
            3'h2:    second_loop_filter_ohms <= LLD_R3_OHM_2;
            3'h3:    second_loop_filter_ohms <= LLD_R3_OHM_3;
            3'h4:    second_loop_filter_ohms <= LLD_R3_OHM_4;
            default: begin
               second_loop_filter_ohms     <= 15'h0000;
               second_loop_filter_code_bad <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   a_dac_div_one: assert property (@(posedge clk) disable iff (!nrst)
      first_phase.valid && dac_div_eff == 10'h001 |=> tune_dac_update)
      else $error("divisor one did not update on every cycle");

   a_dac_update_cause: assert property (@(posedge clk) disable iff (!nrst)
      tune_dac_update |-> $past(first_phase.valid) && $past(dac_cnt_reg) >= $past(dac_div_eff) - 1)
      else $error("tuning update without full divisor count");

   a_ref_div_one: assert property (@(posedge clk) disable iff (!nrst)
      pin_rise[LLD_PIN_REF] && pre_max == 3'h0 && rdiv_eff == 14'h0001 &&
      act_reg == active_input |=> first_loop_ref_tick)
      else $error("undivided reference edge lost");

   a_ref_tick_cause: assert property (@(posedge clk) disable iff (!nrst)
      first_loop_ref_tick |-> $past(pin_rise[LLD_PIN_REF]) && $past(pre_cnt_reg) >= $past(pre_max))
      else $error("reference tick before prescaler completed");

   a_pump2_hiz: assert property (@(posedge clk) disable iff (!nrst)
      cp2_reg[LLD_HIZ_BIT] && $stable(cp2_reg) |=> !second_loop_pump_pin_oe &&
      second_pump.current_ua == 12'h000)
      else $error("loop two pump not released when tri-stated");

   a_pump1_drive: assert property (@(posedge clk) disable iff (!nrst)
      !cp1_reg[LLD_HIZ_BIT] && cp1_reg[LLD_GAIN_LSB +: 2] == 2'h1 && $stable(cp1_reg)
      |=> first_loop_pump_pin_oe && first_pump.current_ua == LLD_CP_200_UA)
      else $error("loop one pump not driven at its current");

   a_delay_step: assert property (@(posedge clk) disable iff (!nrst)
      flt_reg[LLD_NDLY_LSB +: 3] == 3'h7 && $stable(flt_reg) |=>
      first_loop_feedback_delay_ps == 11'd1435)
      else $error("full feedback delay not 1435 ps");

   a_filter_max: assert property (@(posedge clk) disable iff (!nrst)
      flt_reg[LLD_R3_LSB +: 3] == 3'h4 && $stable(flt_reg) |=>
      second_loop_filter_ohms == 15'd16000 && !second_loop_filter_code_bad)
      else $error("filter code 4 not 16 kohm");

   a_doubler_follow: assert property (@(posedge clk) disable iff (!nrst)
      $changed(cp2_reg[LLD_DBL_BIT]) |=> second_loop_reference_doubler_enable == $past(cp2_reg[LLD_DBL_BIT]))
      else $error("doubler output did not follow its bit");

   a_lock_count_kept: assert property (@(posedge clk) disable iff (!nrst)
      (!first_loop_locked || first_count != '0) && (!second_loop_locked || second_count != '0))
      else $error("lock held with an empty counter");

   c_first_lock:  cover property (@(posedge clk) disable iff (!nrst) $rose(first_loop_locked));
   c_second_lock: cover property (@(posedge clk) disable iff (!nrst) $rose(second_loop_locked));
   c_dac_divided: cover property (@(posedge clk) disable iff (!nrst)
      tune_dac_update && dac_div_eff > 10'h002);
   c_input_swap:  cover property (@(posedge clk) disable iff (!nrst)
      act_reg != active_input ##[1:50] first_loop_ref_tick);

endmodule // lld_top

// ---- verification/lld_host_model.sv ----
// Host model that writes configuration frames over the three serial pins
`timescale 1ns/1ps
module lld_host_model (
   // Clock
   input  wire logic clk,
   // Serial pins
   output logic      cfg_sclk,
   output logic      cfg_sdata,
   output logic      cfg_latch
);
   initial begin
      cfg_sclk  = 1'b0;
      cfg_sdata = 1'b0;
      cfg_latch = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   // Four cycles per level clears the three-stage pin filter with margin
   task automatic wr(input logic [4:0] addr, input logic [31:0] data);
      logic [31:0] frame;
      frame = {data[31:5], addr};
      if (addr == 5'h1A) frame[31:30] = 2'h2;
      // Loop-two lock window field (bits 31:30) is always sent as code 2, the only legal code
      for (int i = 31; i >= 0; i--) begin
         cfg_sdata = frame[i];
         hold(4);
         cfg_sclk = 1'b1;
         hold(4);
         cfg_sclk = 1'b0;
      end
      // Released data line shows the inverse of its last bit
      cfg_sdata = ~frame[0];
      cfg_latch = 1'b1;
      hold(4);
      cfg_latch = 1'b0;
      hold(6);
   endtask
endmodule // lld_host_model

// ---- verification/lld_top_tb_top.sv ----
// Self-checking bench for the loop lock and divider configuration block
`timescale 1ns/1ps
module lld_top_tb_top;
   import lld_pkg::*;
   logic       clk, nrst, sclk, sdata, latch, ref_in, lk1, lk2, rtick, dtick, oe1, oe2, dbl, bad;
   logic [1:0] act;
   lld_phase_s ph1, ph2;
   lld_pump_s  pmp1, pmp2;
   logic [10:0] fdly, rdly;
   logic [14:0] ohms;
   int         failures, checks, nref, ndac;

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   lld_top u_lld_top (.clk(clk), .nrst(nrst), .cfg_sclk(sclk), .cfg_sdata(sdata), .cfg_latch(latch),
      .reference_clock_input(ref_in), .active_input(act), .first_phase(ph1), .second_phase(ph2),
      .first_loop_locked(lk1), .second_loop_locked(lk2), .first_loop_ref_tick(rtick),
      .tune_dac_update(dtick), .first_pump(pmp1), .second_pump(pmp2), .first_loop_pump_pin_oe(oe1),
      .second_loop_pump_pin_oe(oe2), .first_loop_feedback_delay_ps(fdly),
      .first_loop_reference_delay_ps(rdly), .second_loop_reference_doubler_enable(dbl),
      .second_loop_filter_ohms(ohms), .second_loop_filter_code_bad(bad));
   lld_host_model u_lld_host_model (.clk(clk), .cfg_sclk(sclk), .cfg_sdata(sdata), .cfg_latch(latch));

   always @(posedge clk) begin
      if (rtick === 1'b1) nref++;
      if (dtick === 1'b1) ndac++;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic pd(input logic two, input logic [15:0] err);
      if (two) ph2 = {1'b1, err};
      else ph1 = {1'b1, err};
      cyc(1);
      ph1.valid = 1'b0;
      ph2.valid = 1'b0;
      cyc(1);
   endtask

   task automatic rises(input int n);
      repeat (n) begin
         ref_in = 1'b1;
         cyc(4);
         ref_in = 1'b0;
         cyc(4);
      end
   endtask

   task automatic complete_run;
      if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_filter;
      logic [14:0] tbl [8] = '{15'd200, 15'd1000, 15'd2000, 15'd4000, 15'd16000, 15'd0, 15'd0, 15'd0};
      for (int c = 0; c < 8; c++) begin
         u_lld_host_model.wr(5'h18, (c << 16) | (c << 12) | (c << 8));
         chk(ohms, tbl[c]);
         chk(bad, c > 4);
         chk(fdly, c * 205);
         chk(rdly, c * 205);
      end
   endtask

   task automatic t_pumps;
      logic [11:0] cur2 [4] = '{12'd100, 12'd400, 12'd1600, 12'd3200};
      logic [11:0] cur1 [4] = '{12'd100, 12'd200, 12'd400, 12'd1600};
      for (int g = 0; g < 4; g++) begin
         u_lld_host_model.wr(5'h1A, ((g & 1) << 29) | (1 << 28) | (g << 26) | (1 << 6));
         chk(pmp2, {1'b1, cur2[g]});
         chk(dbl, g & 1);
         chk(oe2, 1'b1);
         u_lld_host_model.wr(5'h1B, (1 << 28) | (g << 26) | (1 << 6));
         chk(pmp1, {1'b1, cur1[g]});
      end
      u_lld_host_model.wr(5'h1A, (3 << 26) | (1 << 6) | (1 << 5));
      chk(pmp2, 13'h0000);
      chk(oe2, 1'b0);
      u_lld_host_model.wr(5'h1B, (3 << 26) | (1 << 6) | (1 << 5));
      chk(pmp1, 13'h0000);
      chk(oe1, 1'b0);
      // Unmapped address must leave every setting alone
      u_lld_host_model.wr(5'h1C, 32'hFFFF_FFFF);
      chk(oe1, 1'b0);
   endtask

   task automatic t_lock;
      u_lld_host_model.wr(5'h18, 1 << 6);
      u_lld_host_model.wr(5'h19, (2 << 22) | (3 << 6));
      ndac = 0;
      pd(1'b0, 16'd9999);
      pd(1'b0, 16'd9999);
      chk(lk1, 1'b0);
      pd(1'b0, 16'd9999);
      chk(lk1, 1'b1);
      pd(1'b0, 16'd10000);
      chk(lk1, 1'b0);
      chk(ndac, 2);
      u_lld_host_model.wr(5'h1A, 2 << 6);
      pd(1'b1, 16'd3699);
      chk(lk2, 1'b0);
      pd(1'b1, 16'd3699);
      chk(lk2, 1'b1);
      pd(1'b1, 16'd3700);
      chk(lk2, 1'b0);
      // Reserved zero count and divisor both behave as one
      u_lld_host_model.wr(5'h19, 32'h0000_0000);
      ndac = 0;
      pd(1'b0, 16'd100);
      chk(lk1, 1'b1);
      chk(ndac, 1);
   endtask

   task automatic t_ref;
      u_lld_host_model.wr(5'h1B, (3 << 24) | (1 << 22) | (2 << 20) | (3 << 6));
      act = 2'd1;
      cyc(2);
      nref = 0;
      rises(12);
      chk(nref, 2);
      act = 2'd0;
      cyc(2);
      nref = 0;
      rises(24);
      chk(nref, 2);
      act = 2'd2;
      cyc(2);
      nref = 0;
      rises(24);
      chk(nref, 1);
      // Missing input three falls back to the prescaler of input zero
      act = 2'd3;
      cyc(2);
      nref = 0;
      rises(24);
      chk(nref, 2);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      nrst = 1'b0;
      ref_in = 1'b0;
      act = 2'd0;
      ph1 = '0;
      ph2 = '0;
      cyc(16);
      nrst = 1'b1;
      cyc(2);
      chk(ohms, 15'd200);
      chk(pmp1, {1'b0, LLD_CP_100_UA});
      chk(pmp2, {1'b0, LLD_CP_100_UA});
      chk(oe1, 1'b1);
      chk(lk2, 1'b0);
      t_filter();
      t_pumps();
      t_lock();
      t_ref();
      complete_run();
   end

   initial begin
      #2500000;
      failures++;
      complete_run();
   end
endmodule // lld_top_tb_top
